/* hw/pis_slave.sv */
`include "pis_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module pis_slave (
    input  wire logic           clk,
    input  wire logic           rstn,
    pis_bus_if.slave            bus,
    input  wire logic           interface_supply_ok,
    input  wire logic [7:0]     status_in,
    output logic      [7:0]     cmd_out,
    output logic      [7:0]     sub_addr_out,
    output logic                cmd_update
);
    import pis_pkg::*;
    localparam int GC = `PIS_GLITCH_CYC;
    // ************************************************
    // Synchronisers and glitch filters
    // ************************************************
    logic [1:0] scl_sync_reg;
    logic [1:0] sda_sync_reg;
    logic [1:0] sup_sync_reg;
    logic       scl_f_reg;
    logic       sda_f_reg;
    logic [3:0] scl_cnt_reg;
    logic [3:0] sda_cnt_reg;
    logic       scl_d_reg;
    logic       sda_d_reg;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            sup_sync_reg <= 2'h0;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], bus.scl_line};
            sda_sync_reg <= {sda_sync_reg[0], bus.sda_line};
            sup_sync_reg <= {sup_sync_reg[0], interface_supply_ok};
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            scl_f_reg   <= 1'b1;
            sda_f_reg   <= 1'b1;
            scl_cnt_reg <= 4'h0;
            sda_cnt_reg <= 4'h0;
        end else begin
            if (scl_sync_reg[1] == scl_f_reg) begin
                scl_cnt_reg <= 4'h0;
            end else if (scl_cnt_reg == 4'(GC - 1)) begin
                scl_f_reg   <= scl_sync_reg[1];
                scl_cnt_reg <= 4'h0;
            end else begin
                scl_cnt_reg <= scl_cnt_reg + 4'h1;
            end
            if (sda_sync_reg[1] == sda_f_reg) begin
                sda_cnt_reg <= 4'h0;
            end else if (sda_cnt_reg == 4'(GC - 1)) begin
                sda_f_reg   <= sda_sync_reg[1];
                sda_cnt_reg <= 4'h0;
            end else begin
                sda_cnt_reg <= sda_cnt_reg + 4'h1;
            end
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_d_reg <= scl_f_reg;
            sda_d_reg <= sda_f_reg;
        end
    end
    // ************************************************
    // Bus conditions and edges
    // ************************************************
    wire start_det = scl_f_reg && scl_d_reg && sda_d_reg && !sda_f_reg;
    wire stop_det  = scl_f_reg && scl_d_reg && !sda_d_reg && sda_f_reg;
    wire scl_rise  = scl_f_reg && !scl_d_reg;
    wire scl_fall  = !scl_f_reg && scl_d_reg;
    wire supply_ok = sup_sync_reg[1];
    // ************************************************
    // Byte engine
    // ************************************************
    pis_state_type state_reg;
    logic [7:0]    shift_reg;
    logic [2:0]    bit_reg;
    logic [1:0]    wcount_reg;
    logic [7:0]    hold_reg;
    logic [7:0]    sub_reg;
    logic          hold_valid_reg;
    logic          sda_low_reg;
    logic [7:0]    cmd_reg;
    logic          upd_reg;
    wire  [7:0] rx_byte   = {shift_reg[6:0], sda_f_reg};
    wire        addr_wr   = rx_byte == `PIS_WR_ADDR;
    wire        addr_rd   = rx_byte == `PIS_RD_ADDR;
    wire        last_bit  = bit_reg == 3'h7;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg      <= PIS_IDLE;
            shift_reg      <= 8'h00;
            bit_reg        <= 3'h0;
            wcount_reg     <= 2'h0;
            hold_reg       <= 8'h00;
            sub_reg        <= 8'h00;
            hold_valid_reg <= 1'b0;
            sda_low_reg    <= 1'b0;
            cmd_reg        <= `PIS_CMD_RESET;
            upd_reg        <= 1'b0;
        end else if (!supply_ok) begin
            state_reg      <= PIS_IDLE;
            sda_low_reg    <= 1'b0;
            hold_valid_reg <= 1'b0;
            hold_reg       <= 8'h00;
            sub_reg        <= 8'h00;
            cmd_reg        <= `PIS_CMD_RESET;
            upd_reg        <= 1'b0;
        end else begin
            upd_reg <= 1'b0;
            if (stop_det) begin
                state_reg   <= PIS_IDLE;
                sda_low_reg <= 1'b0;
                if (hold_valid_reg) begin
                    cmd_reg        <= hold_reg;
                    upd_reg        <= 1'b1;
                    hold_valid_reg <= 1'b0;
                end
            end else if (start_det) begin
                state_reg   <= PIS_ADDR;
                bit_reg     <= 3'h0;
                sda_low_reg <= 1'b0;
            end else begin
                case (state_reg)
                    PIS_ADDR, PIS_WBYTE: begin
                        if (scl_rise) begin
                            shift_reg <= rx_byte;
                            bit_reg   <= bit_reg + 3'h1;
                            if (last_bit && state_reg == PIS_ADDR) begin
                                if (addr_wr) begin
                                    state_reg  <= PIS_ADDR_ACK;
                                    wcount_reg <= 2'h0;
                                end else if (addr_rd) begin
                                    state_reg <= PIS_ADDR_ACK;
                                    shift_reg <= status_in;
                                end else begin
                                    state_reg <= PIS_IGNORE;
                                end
                            end else if (last_bit) begin
                                state_reg <= PIS_WACK;
                                if (wcount_reg == 2'h0) begin
                                    sub_reg <= rx_byte;
                                end else begin
                                    hold_reg       <= rx_byte;
                                    hold_valid_reg <= 1'b1;
                                end
                                wcount_reg <= wcount_reg + 2'h1;
                            end
                        end
                    end
                    PIS_ADDR_ACK, PIS_WACK: begin
                        if (scl_fall && !sda_low_reg) begin
                            sda_low_reg <= 1'b1;
                        end else if (scl_fall && sda_low_reg) begin
                            sda_low_reg <= 1'b0;
                            bit_reg     <= 3'h0;
                            if (state_reg == PIS_WACK && wcount_reg == 2'h2) begin
                                state_reg <= PIS_IGNORE;
                            end else if (state_reg == PIS_WACK
                                         || shift_reg == `PIS_WR_ADDR) begin
                                state_reg <= PIS_WBYTE;
                            end else begin
                                state_reg   <= PIS_RBYTE;
                                sda_low_reg <= !shift_reg[7];
                            end
                        end
                    end
                    PIS_RBYTE: begin
                        if (scl_fall) begin
                            bit_reg <= bit_reg + 3'h1;
                            if (last_bit) begin
                                state_reg   <= PIS_RACK;
                                sda_low_reg <= 1'b0;
                            end else begin
                                shift_reg   <= {shift_reg[6:0], 1'b0};
                                sda_low_reg <= !shift_reg[6];
                            end
                        end
                    end
                    PIS_RACK: begin
                        if (scl_fall) begin
                            state_reg <= PIS_IGNORE;
                        end
                    end
                    default: begin
                        sda_low_reg <= 1'b0;
                    end
                endcase
            end
        end
    end
    // ************************************************
    // Pin drive and outputs
    // ************************************************
    assign bus.sda_s_o  = 1'b0;
    assign bus.sda_s_oe = sda_low_reg;
    assign cmd_out      = cmd_reg;
    assign sub_addr_out = sub_reg;
    assign cmd_update   = upd_reg;
endmodule
`default_nettype wire

/* hw/pis_defines.svh */
`ifndef PIS_DEFINES_SVH
`define PIS_DEFINES_SVH
`define PIS_WR_ADDR      8'h12
`define PIS_RD_ADDR      8'h13
`define PIS_CMD_RESET    8'h00
`define PIS_CLK_MHZ      250
`define PIS_SCL_KHZ      400
`define PIS_GLITCH_NS    50
`define PIS_GLITCH_CYC   ((`PIS_GLITCH_NS * `PIS_CLK_MHZ + 999) / 1000)
`define PIS_HALF_CYC     ((`PIS_CLK_MHZ * 1000) / (`PIS_SCL_KHZ * 2))
`endif

/* hw/pis_pkg.sv */
package pis_pkg;
    typedef enum logic [2:0] {
        PIS_IDLE,
        PIS_ADDR,
        PIS_ADDR_ACK,
        PIS_WBYTE,
        PIS_WACK,
        PIS_RBYTE,
        PIS_RACK,
        PIS_IGNORE
    } pis_state_type;
    typedef enum logic [3:0] {
        PIM_IDLE,
        PIM_START,
        PIM_BIT_LO,
        PIM_BIT_HI,
        PIM_STOP_LO,
        PIM_STOP_HI,
        PIM_DONE
    } pis_mst_type;
endpackage

/* hw/pis_bus_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface pis_bus_if;
    logic scl_o;
    logic scl_oe;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_s_o;
    logic sda_s_oe;
    wire  scl_line;
    wire  sda_line;
    // ************************************************
    // Open-drain wired-and with pull-ups
    // ************************************************
    assign scl_line = !(scl_oe && !scl_o);
    assign sda_line = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
    modport master (output scl_o, scl_oe, sda_m_o, sda_m_oe, input scl_line, sda_line);
    modport slave  (output sda_s_o, sda_s_oe, input scl_line, sda_line);
endinterface
`default_nettype wire

/* hw/pis_master.sv */
`include "pis_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module pis_master (
    input  wire logic           clk,
    input  wire logic           rstn,
    pis_bus_if.master           bus,
    input  wire logic           req,
    input  wire logic           req_read,
    input  wire logic [7:0]     req_sub,
    input  wire logic [7:0]     req_data,
    output logic                busy,
    output logic                done,
    output logic                ack_err,
    output logic      [7:0]     rd_data
);
    import pis_pkg::*;
    localparam int HC = `PIS_HALF_CYC;
    // ************************************************
    // Clock rate divider
    // ************************************************
    logic [9:0] div_reg;
    logic [1:0] sda_sync_reg;
    wire        tick = div_reg == 10'(HC - 1);
    wire        mid  = div_reg == 10'(HC / 2 - 1);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            div_reg      <= 10'h000;
            sda_sync_reg <= 2'h3;
        end else begin
            div_reg      <= tick ? 10'h000 : div_reg + 10'h001;
            sda_sync_reg <= {sda_sync_reg[0], bus.sda_line};
        end
    end
    // ************************************************
    // Transfer sequencer
    // ************************************************
    pis_mst_type   state_reg;
    logic [26:0]   tx_reg;
    logic [4:0]    bits_reg;
    logic [4:0]    nbits_reg;
    logic          rd_reg;
    logic          scl_reg;
    logic          sda_reg;
    logic          err_reg;
    logic          done_reg;
    logic [7:0]    rdata_reg;
    wire  [4:0] pos  = bits_reg;
    wire        ackb = pos == 5'd8 || pos == 5'd17 || pos == 5'd26;
    wire        rdat = rd_reg && pos > 5'd8 && pos < 5'd17;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= PIM_IDLE;
            tx_reg    <= 27'h0;
            bits_reg  <= 5'h00;
            nbits_reg <= 5'h00;
            rd_reg    <= 1'b0;
            scl_reg   <= 1'b1;
            sda_reg   <= 1'b1;
            err_reg   <= 1'b0;
            done_reg  <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            done_reg <= 1'b0;
            case (state_reg)
                PIM_IDLE: begin
                    if (req) begin
                        rd_reg    <= req_read;
                        tx_reg    <= req_read ? {`PIS_RD_ADDR, 1'b1, 8'hff, 1'b0, 9'h1ff}
                                    : {`PIS_WR_ADDR, 1'b1, req_sub, 1'b1, req_data, 1'b1};
                        nbits_reg <= req_read ? 5'd18 : 5'd27;
                        err_reg   <= 1'b0;
                        bits_reg  <= 5'h00;
                        state_reg <= PIM_START;
                    end
                end
                PIM_START: begin
                    if (tick) begin
                        sda_reg   <= 1'b0;
                        state_reg <= PIM_BIT_LO;
                    end
                end
                PIM_BIT_LO: begin
                    if (tick && scl_reg) begin
                        scl_reg <= 1'b0;
                    end else if (mid && !scl_reg) begin
                        sda_reg <= tx_reg[26];
                    end else if (tick) begin
                        scl_reg   <= 1'b1;
                        state_reg <= PIM_BIT_HI;
                    end
                end
                PIM_BIT_HI: begin
                    if (tick) begin
                        scl_reg  <= 1'b0;
                        tx_reg   <= {tx_reg[25:0], 1'b1};
                        bits_reg <= bits_reg + 5'h01;
                        if (ackb && !rdat && sda_sync_reg[1]) begin
                            err_reg <= 1'b1;
                        end
                        if (rdat) begin
                            rdata_reg <= {rdata_reg[6:0], sda_sync_reg[1]};
                        end
                        state_reg <= bits_reg + 5'h01 == nbits_reg ? PIM_STOP_LO : PIM_BIT_LO;
                    end
                end
                PIM_STOP_LO: begin
                    if (mid) begin
                        sda_reg <= 1'b0;
                    end else if (tick) begin
                        scl_reg   <= 1'b1;
                        state_reg <= PIM_STOP_HI;
                    end
                end
                PIM_STOP_HI: begin
                    if (tick) begin
                        sda_reg   <= 1'b1;
                        state_reg <= PIM_DONE;
                    end
                end
                default: begin
                    done_reg  <= 1'b1;
                    state_reg <= PIM_IDLE;
                end
            endcase
        end
    end
    // ************************************************
    // Open-drain drive and outputs
    // ************************************************
    assign bus.scl_o    = 1'b0;
    assign bus.scl_oe   = !scl_reg;
    assign bus.sda_m_o  = 1'b0;
    assign bus.sda_m_oe = !sda_reg;
    assign busy         = state_reg != PIM_IDLE;
    assign done         = done_reg;
    assign ack_err      = err_reg;
    assign rd_data      = rdata_reg;
endmodule
`default_nettype wire

/* sim/pis_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module pis_assertions (
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic       scl_line,
    input wire logic       sda_line,
    input wire logic       sda_s_oe,
    input wire logic       interface_supply_ok,
    input wire logic [7:0] cmd_out,
    input wire logic       cmd_update
);
    // ************************************************
    // Bit and byte tracking on the raw wires
    // ************************************************
    logic       scl_q;
    logic       sda_q;
    logic [3:0] bit_cnt;
    logic [2:0] byte_idx;
    logic [7:0] shift_reg;
    logic       rd_reg;
    logic       match_reg;
    wire        scl_rise   = scl_line && !scl_q;
    wire        start_ev   = scl_line && scl_q && sda_q && !sda_line;
    wire        addr_match = (shift_reg == 8'h12) || (shift_reg == 8'h13);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            scl_q     <= 1'b1;
            sda_q     <= 1'b1;
            bit_cnt   <= 4'h0;
            byte_idx  <= 3'h7;
            shift_reg <= 8'h00;
            rd_reg    <= 1'b0;
            match_reg <= 1'b0;
        end else begin
            scl_q <= scl_line;
            sda_q <= sda_line;
            if (start_ev) begin
                bit_cnt  <= 4'h0;
                byte_idx <= 3'h0;
            end else if (scl_rise && bit_cnt == 4'h8) begin
                bit_cnt  <= 4'h0;
                byte_idx <= byte_idx + {2'h0, byte_idx != 3'h7};
                if (byte_idx == 3'h0) begin
                    rd_reg    <= shift_reg[0];
                    match_reg <= addr_match;
                end
            end else if (scl_rise) begin
                bit_cnt   <= bit_cnt + 4'h1;
                shift_reg <= {shift_reg[6:0], sda_line};
            end
        end
    end
    // ************************************************
    // Properties
    // ************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_ack_slot;
        scl_rise && bit_cnt == 4'h8;
    endsequence
    sequence s_supply_low;
        (!interface_supply_ok) [*4];
    endsequence
    a_addr_ack_low: assert property (
        s_ack_slot ##0 (byte_idx == 3'h0 && addr_match) |-> !sda_line)
        else $error("address not acknowledged");
    a_unmatched_free: assert property (
        s_ack_slot ##0 (byte_idx == 3'h0 && !addr_match) |-> !sda_s_oe)
        else $error("unmatched address acknowledged");
    a_wdata_ack_low: assert property (
        s_ack_slot ##0 (byte_idx inside {3'h1, 3'h2} && !rd_reg && match_reg) |-> !sda_line)
        else $error("write byte not acknowledged");
    a_no_extra_ack: assert property (
        s_ack_slot ##0 (byte_idx != 3'h0 && (rd_reg || !match_reg || byte_idx >= 3'h3))
        |-> !sda_s_oe)
        else $error("acknowledge where none is due");
    a_quiet_scl_high: assert property (
        scl_line && scl_q && interface_supply_ok |-> $stable(sda_s_oe))
        else $error("slave data moved while clock high");
    a_supply_clears: assert property (s_supply_low |-> cmd_out == 8'h00 && !sda_s_oe)
        else $error("low supply did not clear port");
    a_cmd_on_update: assert property (
        $changed(cmd_out) |-> cmd_update || $past(cmd_update) || !$past(interface_supply_ok))
        else $error("command changed without update");
    a_update_pulse: assert property (cmd_update |=> !cmd_update)
        else $error("update longer than one cycle");
    a_update_bus_free: assert property (cmd_update |-> scl_line && sda_line)
        else $error("update while bus in use");
endmodule
`default_nettype wire

/* sim/pmic_i2c_slave_port_test.sv */
`timescale 1ns/100ps
`default_nettype none
module pmic_i2c_slave_port_test;
    logic       clk;
    logic       rstn;
    logic       req;
    logic       req_read;
    logic [7:0] req_sub;
    logic [7:0] req_data;
    logic       busy;
    logic       done;
    logic       ack_err;
    logic [7:0] rd_data;
    logic       interface_supply_ok;
    logic [7:0] status_in;
    logic [7:0] cmd_out;
    logic [7:0] sub_addr_out;
    logic       cmd_update;
    int         mismatches = 0;
    int         n_checks   = 0;
    int         n_upd      = 0;
    int         bitn       = 9;
    logic [7:0] mon_byte   = 8'h00;
    logic       mon_ack    = 1'b1;
    pis_bus_if bus_if ();
    pis_master i_pis_master (.clk(clk), .rstn(rstn), .bus(bus_if), .req(req), .req_read(req_read),
        .req_sub(req_sub), .req_data(req_data), .busy(busy), .done(done), .ack_err(ack_err),
        .rd_data(rd_data));
    pis_slave i_pis_slave (.clk(clk), .rstn(rstn), .bus(bus_if),
        .interface_supply_ok(interface_supply_ok), .status_in(status_in), .cmd_out(cmd_out),
        .sub_addr_out(sub_addr_out), .cmd_update(cmd_update));
    pis_assertions i_pis_assertions (.clk(clk), .rstn(rstn), .scl_line(bus_if.scl_line),
        .sda_line(bus_if.sda_line), .sda_s_oe(bus_if.sda_s_oe),
        .interface_supply_ok(interface_supply_ok), .cmd_out(cmd_out), .cmd_update(cmd_update));
    // ************************************************
    // Clock, reset, wire monitor
    // ************************************************
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        rstn = 1'b0;
        req = 1'b0;
        req_read = 1'b0;
        req_sub = 8'h00;
        req_data = 8'h00;
        interface_supply_ok = 1'b1;
        status_in = 8'h00;
    end
    always @(posedge clk) if (cmd_update === 1'b1) n_upd++;
    always @(negedge bus_if.sda_line) if (bus_if.scl_line === 1'b1) bitn = 0;
    always @(posedge bus_if.scl_line) begin
        if (bitn < 8) mon_byte = {mon_byte[6:0], bus_if.sda_line};
        if (bitn == 8) mon_ack = bus_if.sda_line;
        bitn++;
    end
    // ************************************************
    // Shared tasks
    // ************************************************
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic do_xfer(input logic rd, input logic [7:0] sub, input logic [7:0] dat);
        int i;
        i = 0;
        req <= 1'b1;
        req_read <= rd;
        req_sub <= sub;
        req_data <= dat;
        @(posedge clk);
        req <= 1'b0;
        @(negedge clk);
        while (done !== 1'b1 && i < 40000) begin
            @(negedge clk);
            i++;
        end
        check("done", {7'h00, done}, 8'h01);
        check("ack_err", {7'h00, ack_err}, 8'h00);
        check("addr ack wire", {7'h00, mon_ack}, 8'h00);
        @(posedge clk);
    endtask
    // ************************************************
    // Scenarios
    // ************************************************
    task automatic t_reset();
        @(negedge clk);
        check("cmd_out reset", cmd_out, 8'h00);
        check("busy reset", {7'h00, busy}, 8'h00);
        check("idle lines", {6'h00, bus_if.scl_line, bus_if.sda_line}, 8'h03);
        @(posedge clk);
    endtask
    task automatic t_write(input logic [7:0] sub, input logic [7:0] dat);
        int u0;
        u0 = n_upd;
        do_xfer(1'b0, sub, dat);
        repeat (24) @(negedge clk);
        check("write address", mon_byte, 8'h12);
        check("cmd_out", cmd_out, dat);
        check("sub_addr_out", sub_addr_out, sub);
        check("update count", 8'(n_upd - u0), 8'h01);
        check("idle lines", {6'h00, bus_if.scl_line, bus_if.sda_line}, 8'h03);
        @(posedge clk);
    endtask
    task automatic t_read(input logic [7:0] st, input logic [7:0] nxt, input logic [7:0] exp);
        logic [7:0] c0;
        c0 = cmd_out;
        status_in <= st;
        fork
            do_xfer(1'b1, 8'h00, 8'h00);
            begin
                repeat (12) @(posedge bus_if.scl_line);
                @(posedge clk);
                status_in <= nxt;
            end
        join
        @(negedge clk);
        check("read address", mon_byte, 8'h13);
        check("rd_data", rd_data, exp);
        check("cmd kept on read", cmd_out, c0);
        @(posedge clk);
    endtask
    task automatic t_supply();
        interface_supply_ok <= 1'b0;
        repeat (4) @(negedge clk);
        check("cmd_out cleared", cmd_out, 8'h00);
        check("sda released", {7'h00, bus_if.sda_line}, 8'h01);
        @(posedge clk);
        interface_supply_ok <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
    // ************************************************
    // Main sequence and watchdog
    // ************************************************
    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_reset();
        t_write(8'h00, 8'hff);
        t_write(8'h00, 8'h01);
        t_read(8'h96, 8'h69, 8'h96);
        t_read(8'h3c, 8'hc3, 8'h3c);
        t_supply();
        t_write(8'h00, 8'ha5);
        give_verdict();
    end
    initial begin
        #400000;
        mismatches++;
        give_verdict();
    end
endmodule
`default_nettype wire
